// ### rtl/cir_pkg.sv
package cir_pkg;
   // number of request lines handled by each controller
   localparam int CTRL_LINES = 8;
   // master request input that carries the slave output
   localparam int CASCADE_LINE = 2;
   // absolute position of the coprocessor line 13, slave input 5
   localparam int FPU_LINE = 13;
   // legacy line-2 pin lands on line 9
   localparam int LEGACY_LINE = 9;
   // bus-interface routing targets
   localparam int BUS_LINE_PRIMARY = 11;
   localparam int BUS_LINE_ALT_HI = 12;
   localparam int BUS_LINE_ALT_LO = 5;
   // synchroniser depth for pin inputs
   localparam int SYNC_STAGES = 2;
   // acknowledge to vector latency in mclk cycles
   localparam int ACK_LATENCY = 2;
   // reset values
   localparam logic [7:0] VECTOR_RESET = 8'h00;
   localparam logic [2:0] LINE_RESET = 3'h0;

   // where the bus-interface interrupt goes among the maskable lines
   typedef enum logic [1:0] {
      CIR_ROUTE_PRIMARY = 2'b00, // line 11
      CIR_ROUTE_ALT_HI = 2'b01,  // line 12
      CIR_ROUTE_ALT_LO = 2'b10,  // line 5
      CIR_ROUTE_NONE = 2'b11     // maskable path off, only the nmi path
   } cir_route_type;
endpackage

// ### rtl/cir_prio_ctrl.sv
`timescale 1ns/1ps
// one fixed-priority controller: lowest line number wins
module cir_prio_ctrl #(
   parameter int LINES = 8
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [LINES-1:0] req,
   input wire logic [LINES-1:0] mask,
   input wire logic [7:0] base,
   input wire logic ack,
   output logic int_out,
   output logic [7:0] vector,
   output logic [$clog2(LINES)-1:0] ack_line
);
   localparam int LW = $clog2(LINES);

   // the vector keeps base high bits, so line count must be a power of two
   generate
      if (LINES < 2 || LINES > 8 || (1 << LW) != LINES) begin : g_bad
         $error("cir_prio_ctrl: LINES must be 2, 4 or 8");
      end
   endgenerate

   // unmasked requests
   logic [LINES-1:0] pending;
   // winning line this cycle
   logic [LW-1:0] win;

   // index of the lowest set bit; all-zero gives the last line (spurious)
   function automatic logic [LW-1:0] first_set(input logic [LINES-1:0] v);
      logic [LW-1:0] idx;
      idx = LW'(LINES - 1);
      for (int i = LINES - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = LW'(i);
         end
      end
      return idx;
   endfunction

   assign pending = req & ~mask;
   assign win = first_set(pending);
   // level output, host sees it the same cycle a line rises
   assign int_out = |pending;

   // capture the vector at the acknowledge edge, held until the next one
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         vector <= cir_pkg::VECTOR_RESET;
      end else if (ack) begin
         vector <= {base[7:LW], win};
      end
   end

   // remember which line won, the top needs it for the cascade choice
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ack_line <= LW'(cir_pkg::LINE_RESET);
      end else if (ack) begin
         ack_line <= win;
      end
   end
endmodule

// ### rtl/cir_routing.sv
`timescale 1ns/1ps
module cir_routing (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [15:0] ext_irq,
   input wire logic fpu_irq,
   input wire logic bus_irq,
   input wire logic parity_err,
   input wire logic [1:0] bus_route,
   input wire logic bus_nmi_en,
   input wire logic nmi_enable,
   input wire logic [7:0] master_base,
   input wire logic [7:0] slave_base,
   input wire logic [7:0] master_mask,
   input wire logic [7:0] slave_mask,
   input wire logic inta,
   output logic intr,
   output logic [7:0] int_vector,
   output logic vector_valid,
   output logic nmi
);
   // pin group sampled through the synchroniser
   localparam int PINS = 19;

   // first and second synchroniser stages
   logic [PINS-1:0] sync_a;
   logic [PINS-1:0] sync_b;
   // synchronised pin views
   logic [15:0] ext_s;
   logic fpu_s;
   logic bus_s;
   logic parity_s;
   // sixteen request lines as seen by the two controllers
   logic [15:0] lines;
   // master requests with the cascade line spliced in
   logic [7:0] master_req;
   logic slave_int;
   logic master_int;
   logic [7:0] master_vec;
   logic [7:0] slave_vec;
   logic [2:0] master_line;
   // acknowledge delayed to line up with the controller vectors
   logic ack_d;
   // decoded route
   cir_pkg::cir_route_type route;
   logic [15:0] next_lines;

   // pins come from other boards, so two flops before anything reads them
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= {ext_irq, fpu_irq, bus_irq, parity_err};
         sync_b <= sync_a;
      end
   end

   assign ext_s = sync_b[18:3];
   assign fpu_s = sync_b[2];
   assign bus_s = sync_b[1];
   assign parity_s = sync_b[0];
   assign route = cir_pkg::cir_route_type'(bus_route);

   // build the request lines; external bits 2 and 13 are ignored here
   always_comb begin
      next_lines = ext_s;
      next_lines[cir_pkg::CASCADE_LINE] = 1'b0;
      next_lines[cir_pkg::FPU_LINE] = fpu_s;
      // bit 9 of the pin group is the legacy line-2 expansion pin
      next_lines[cir_pkg::LEGACY_LINE] = ext_s[cir_pkg::LEGACY_LINE];
      case (route)
         cir_pkg::CIR_ROUTE_PRIMARY: begin
            next_lines[cir_pkg::BUS_LINE_PRIMARY] = ext_s[cir_pkg::BUS_LINE_PRIMARY] | bus_s;
         end
         cir_pkg::CIR_ROUTE_ALT_HI: begin
            next_lines[cir_pkg::BUS_LINE_ALT_HI] = ext_s[cir_pkg::BUS_LINE_ALT_HI] | bus_s;
         end
         cir_pkg::CIR_ROUTE_ALT_LO: begin
            next_lines[cir_pkg::BUS_LINE_ALT_LO] = ext_s[cir_pkg::BUS_LINE_ALT_LO] | bus_s;
         end
         default: begin
            // bus interrupt reaches the host only through the nmi path
         end
      endcase
   end
   assign lines = next_lines;

   // master line 2 is the slave output, nothing else can claim it
   always_comb begin
      master_req = lines[7:0];
      master_req[cir_pkg::CASCADE_LINE] = slave_int;
   end

   // slave handles lines 8..15
   cir_prio_ctrl #(.LINES(cir_pkg::CTRL_LINES)) u_slave (
      .mclk(mclk),
      .rst(rst),
      .req(lines[15:8]),
      .mask(slave_mask),
      .base(slave_base),
      .ack(inta),
      .int_out(slave_int),
      .vector(slave_vec),
      .ack_line()
   );

   // master handles lines 0..7 and sees the slave on line 2
   cir_prio_ctrl #(.LINES(cir_pkg::CTRL_LINES)) u_master (
      .mclk(mclk),
      .rst(rst),
      .req(master_req),
      .mask(master_mask),
      .base(master_base),
      .ack(inta),
      .int_out(master_int),
      .vector(master_vec),
      .ack_line(master_line)
   );

   assign intr = master_int;

   // both controllers latch on the same edge; the slave vector is
   // thrown away unless the master picked the cascade line
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ack_d <= 1'b0;
      end else begin
         ack_d <= inta;
      end
   end

   // vector register and its one-cycle strobe
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         int_vector <= cir_pkg::VECTOR_RESET;
         vector_valid <= 1'b0;
      end else begin
         vector_valid <= ack_d;
         if (ack_d) begin
            if (master_line == 3'(cir_pkg::CASCADE_LINE)) begin
               int_vector <= slave_vec;
            end else begin
               int_vector <= master_vec;
            end
         end
      end
   end

   // nmi is a level; the host setup gate must be open for it to show
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         nmi <= 1'b0;
      end else begin
         nmi <= nmi_enable & (parity_s | (bus_s & bus_nmi_en));
      end
   end

   // ---------------- assertions ----------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_ack;
      inta;
   endsequence
   sequence s_answer;
      // a back-to-back acknowledge keeps the strobe up one more cycle
      ##1 !vector_valid ##1 vector_valid ##1 (!vector_valid || $past(inta, 2));
   endsequence

   property p_intr_any;
      // expected from the raw lines, not from the controller's own output
      intr == ((|(lines[7:0] & ~master_mask & ~(8'h01 << cir_pkg::CASCADE_LINE)))
         || (!master_mask[cir_pkg::CASCADE_LINE] && (|(lines[15:8] & ~slave_mask))));
   endproperty
   a_intr_any: assert property (p_intr_any) else $error("intr not tied to pending");

   property p_cascade_only;
      master_req[cir_pkg::CASCADE_LINE] == (|(lines[15:8] & ~slave_mask));
   endproperty
   a_cascade_only: assert property (p_cascade_only) else $error("line 2 not cascade");

   property p_fpu_line;
      $rose(fpu_irq) && !inta |-> ##2 lines[cir_pkg::FPU_LINE];
   endproperty
   a_fpu_line: assert property (p_fpu_line) else $error("fpu line not followed");

   property p_legacy;
      ext_irq[cir_pkg::LEGACY_LINE] |-> ##2 lines[cir_pkg::LEGACY_LINE];
   endproperty
   a_legacy: assert property (p_legacy) else $error("legacy pin not on line 9");

   property p_vector_timing;
      s_ack and !ack_d |-> s_answer;
   endproperty
   a_vector_timing: assert property (p_vector_timing) else $error("vector strobe late");

   property p_route_primary;
      route == cir_pkg::CIR_ROUTE_PRIMARY && bus_s |-> lines[cir_pkg::BUS_LINE_PRIMARY];
   endproperty
   a_route_primary: assert property (p_route_primary) else $error("bus not on 11");

   property p_route_hi;
      route == cir_pkg::CIR_ROUTE_ALT_HI && bus_s |-> lines[cir_pkg::BUS_LINE_ALT_HI];
   endproperty
   a_route_hi: assert property (p_route_hi) else $error("bus not on 12");

   property p_route_lo;
      route == cir_pkg::CIR_ROUTE_ALT_LO && bus_s |-> lines[cir_pkg::BUS_LINE_ALT_LO];
   endproperty
   a_route_lo: assert property (p_route_lo) else $error("bus not on 5");

   property p_nmi;
      nmi_enable && parity_s && $stable(nmi_enable) |=> nmi;
   endproperty
   a_nmi: assert property (p_nmi) else $error("parity error missed nmi");

   property p_nmi_gate;
      !nmi_enable |=> !nmi;
   endproperty
   a_nmi_gate: assert property (p_nmi_gate) else $error("nmi while disabled");

   property p_cascade_vec;
      ack_d && master_line == 3'(cir_pkg::CASCADE_LINE) |=> int_vector == $past(slave_vec);
   endproperty
   a_cascade_vec: assert property (p_cascade_vec) else $error("slave vector not used");
endmodule

// ### test/cir_host.sv
`timescale 1ns/1ps
// host side: programs both controllers at boot and acknowledges requests
module cir_host (
   input wire logic mclk,
   input wire logic rst,
   input wire logic nmi_on,
   input wire logic [7:0] int_vector,
   input wire logic vector_valid,
   output logic inta,
   output logic [7:0] master_base,
   output logic [7:0] slave_base,
   output logic nmi_enable
);
   // byte offset of the handler pointer, four bytes per table entry
   logic [9:0] table_index;
   // firmware writes base vectors before any request is serviced
   initial begin
      inta = 1'b0;
      table_index = 10'h000;
      master_base = 8'h08;
      slave_base = 8'h70;
   end
   // board nmi only reaches the processor once setup enables it
   assign nmi_enable = nmi_on;
   // one-cycle acknowledge pulse, then a bounded wait for the vector
   task automatic acknowledge(output logic [7:0] vec, output int lat);
      vec = 8'h00;
      lat = -1;
      @(negedge mclk);
      inta = 1'b1;
      @(negedge mclk);
      inta = 1'b0;
      // a missing answer leaves lat negative so the caller sees it
      for (int i = 0; i < 6; i++) begin
         @(negedge mclk);
         if (vector_valid === 1'b1 && lat < 0) begin
            vec = int_vector;
            // rising edges from the taking edge to the one that samples the strobe
            lat = i + 2;
            table_index = {int_vector, 2'b00};
         end
      end
   endtask
endmodule

// ### test/cir_routing_bench.sv
`timescale 1ns/1ps
// drives the request pins and judges vectors taken by the host model
module cir_routing_bench;
   logic mclk, rst, fpu_irq, bus_irq, parity_err, bus_nmi_en, nmi_on;
   logic [15:0] ext_irq;
   logic [1:0] bus_route;
   logic [7:0] master_mask, slave_mask;
   logic inta, intr, vector_valid, nmi, nmi_enable;
   logic [7:0] master_base, slave_base, int_vector;
   int failures = 0;
   int tests_run = 0;
   cir_routing u_dut (.mclk(mclk), .rst(rst), .ext_irq(ext_irq), .fpu_irq(fpu_irq),
      .bus_irq(bus_irq), .parity_err(parity_err), .bus_route(bus_route),
      .bus_nmi_en(bus_nmi_en), .nmi_enable(nmi_enable), .master_base(master_base),
      .slave_base(slave_base), .master_mask(master_mask), .slave_mask(slave_mask),
      .inta(inta), .intr(intr), .int_vector(int_vector), .vector_valid(vector_valid),
      .nmi(nmi));
   cir_host u_host (.mclk(mclk), .rst(rst), .nmi_on(nmi_on), .int_vector(int_vector),
      .vector_valid(vector_valid), .inta(inta), .master_base(master_base),
      .slave_base(slave_base), .nmi_enable(nmi_enable));
   // 200 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // one comparison, reported at once when it differs
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // pins pass two sync flops, so give them a margin before acting
   task automatic settle();
      repeat (4) @(negedge mclk);
   endtask
   // acknowledge through the host and judge vector and latency
   task automatic ack_check(input logic [7:0] exp);
      logic [7:0] v;
      int lat;
      u_host.acknowledge(v, lat);
      check(v, exp);
      check(lat[7:0], 8'(cir_pkg::ACK_LATENCY));
   endtask
   // slave request through the cascade beats master line 3
   task automatic t_cascade();
      ext_irq = 16'h0218;
      settle();
      check({7'h00, intr}, 8'h01);
      ack_check(8'h71);
      slave_mask = 8'h02;
      settle();
      ack_check(8'h0b);
      slave_mask = 8'h00;
      // master mask hides the cascade and line 3, so line 4 wins
      master_mask = 8'h0c;
      settle();
      ack_check(8'h0c);
      master_mask = 8'h00;
      ext_irq = 16'h0000;
   endtask
   // cascade and coprocessor pins are not external sources
   task automatic t_reserved();
      ext_irq = 16'h2004;
      settle();
      check({7'h00, intr}, 8'h00);
      ack_check(8'h0f);
      ext_irq = 16'h0000;
      fpu_irq = 1'b1;
      settle();
      ack_check(8'h75);
      fpu_irq = 1'b0;
   endtask
   // every routing choice of the bus interrupt
   task automatic t_route();
      logic [7:0] tbl [4];
      tbl = '{8'h73, 8'h74, 8'h0d, 8'h0f};
      bus_irq = 1'b1;
      for (int r = 0; r < 4; r++) begin
         bus_route = r[1:0];
         settle();
         check({7'h00, intr}, {7'h00, r != 3});
         ack_check(tbl[r]);
      end
      bus_irq = 1'b0;
   endtask
   // nmi sources against the setup gate; bus routed off the maskable lines
   task automatic t_nmi();
      logic [2:0] cfg [4];
      logic exp [4];
      cfg = '{3'b110, 3'b011, 3'b101, 3'b100};
      exp = '{1'b1, 1'b0, 1'b1, 1'b0};
      bus_irq = 1'b1;
      for (int k = 0; k < 4; k++) begin
         {nmi_on, parity_err, bus_nmi_en} = cfg[k];
         settle();
         check({7'h00, nmi}, {7'h00, exp[k]});
      end
      {bus_irq, parity_err, bus_nmi_en} = 3'b000;
   endtask
   // reset in mid-run clears vector, strobe and nmi, then service resumes
   task automatic t_reset();
      {nmi_on, parity_err} = 2'b11;
      settle();
      check({7'h00, nmi}, 8'h01);
      rst = 1'b1;
      repeat (2) @(negedge mclk);
      check(int_vector, cir_pkg::VECTOR_RESET);
      check({6'h00, vector_valid, nmi}, 8'h00);
      rst = 1'b0;
      // one edge after release the parity pin is still inside the synchroniser
      @(negedge mclk);
      check({7'h00, nmi}, 8'h00);
      settle();
      check({7'h00, nmi}, 8'h01);
      {nmi_on, parity_err} = 2'b00;
      ack_check(8'h0f);
   endtask
   // verdict and end of run
   task automatic print_verdict();
      if (failures == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // main sequence, inputs changed on falling edges only
   initial begin
      {fpu_irq, bus_irq, parity_err, bus_nmi_en, nmi_on} = 5'h00;
      ext_irq = 16'h0000;
      bus_route = 2'h3;
      master_mask = 8'h00;
      slave_mask = 8'h00;
      rst = 1'b1;
      repeat (10) @(negedge mclk);
      rst = 1'b0;
      t_cascade();
      t_reserved();
      t_route();
      t_nmi();
      t_reset();
      print_verdict();
   end
   // the tests need well under a thousand cycles
   initial begin
      #20000;
      failures++;
      print_verdict();
   end
endmodule
